// ---- core_model.sv ----
// core-side model: pulses one vector acknowledge per pending request
// assumes request levels come registered from the timer block
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       en_in,
  input  wire logic [3:0] delay_in,
  input  wire logic [3:0] req_in,
  output logic      [3:0] ack_out
);
  logic [3:0] cnt_r [4];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 4'h0;
      for (int i = 0; i < 4; i++) cnt_r[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ack_out[i] <= 1'b0;
        cnt_r[i]   <= 4'h0;
        // a slow core vectors delay_in + 1 cycles after the request shows
        if (en_in && req_in[i] && !ack_out[i]) begin
          if (cnt_r[i] == delay_in) ack_out[i] <= 1'b1;
          else cnt_r[i] <= cnt_r[i] + 4'h1;
        end
      end
    end
  end
endmodule : core_model

// ---- dual_timer.sv ----
// dual timer/counter with external interrupt pin flags
// assumes pins are asynchronous inputs and the core pulses one
// acknowledge per source when it vectors to that service routine
`timescale 1ns/1ps
module dual_timer (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       ext_irq_zero_pin_in,
  input  wire logic       ext_irq_one_pin_in,
  input  wire logic       count_zero_pin_in,
  input  wire logic       count_one_pin_in,
  input  wire logic       ack_timer_zero_in,
  input  wire logic       ack_timer_one_in,
  input  wire logic       ack_ext_zero_in,
  input  wire logic       ack_ext_one_in,
  output logic            ext_irq_zero_req_out,
  output logic            ext_irq_one_req_out,
  output logic            timer_zero_overflow_flag_out,
  output logic            timer_one_overflow_flag_out
);
  import timer_pkg::*;

  logic [7:0]           timer_control_r;
  logic [7:0]           timer_mode_r;
  logic [7:0]           timer_zero_low_byte_r;
  logic [7:0]           timer_zero_high_byte_r;
  logic [7:0]           timer_one_low_byte_r;
  logic [7:0]           timer_one_high_byte_r;
  logic [7:0]           rd_data_r;
  logic                 ext_zero_req_r;
  logic                 ext_one_req_r;
  logic [PIN_COUNT-1:0] meta_r;
  logic [PIN_COUNT-1:0] sync_r;
  logic [PIN_COUNT-1:0] prev_r;
  logic [PIN_COUNT-1:0] fall;
  logic                 half_rate_r;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  // returns {overflow, high, low} after one count step
  function automatic logic [16:0] step(input timer_mode_t m,
                                       input logic [7:0]  lo,
                                       input logic [7:0]  hi);
    logic [PRESCALE_BITS:0] pre;
    logic [8:0]             hsum;
    logic [8:0]             lsum;
    logic [16:0]            wide;
    pre  = {1'b0, lo[PRESCALE_BITS-1:0]} + 6'h01;
    hsum = {1'b0, hi} + {8'h00, pre[PRESCALE_BITS]};
    lsum = {1'b0, lo} + 9'h001;
    wide = {1'b0, hi, lo} + 17'h00001;
    case (m)
      MODE_PRESCALED: step = {hsum, lo[7:PRESCALE_BITS],
                              pre[PRESCALE_BITS-1:0]};
      MODE_WIDE:      step = wide;
      MODE_RELOAD:    step = lsum[8] ? {1'b1, hi, hi}
                                     : {1'b0, hi, lsum[7:0]};
      MODE_SPLIT:     step = {lsum[8], hi, lsum[7:0]};
      default:        step = {1'b0, hi, lo};
    endcase
  endfunction : step

  // sync stage one feeds only stage two; edges use stages two/three
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= {count_one_pin_in, count_zero_pin_in,
                 ext_irq_one_pin_in, ext_irq_zero_pin_in};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign fall = prev_r & ~sync_r;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      half_rate_r <= 1'b0;
    else
      half_rate_r <= ~half_rate_r;
  end

  timer_mode_t m0;
  timer_mode_t m1;
  logic        tick0;
  logic        tick1;
  logic        en0;
  logic        en1;
  logic        adv0;
  logic        adv1;
  logic        adv_h0;
  logic [16:0] st0;
  logic [16:0] st1;
  logic [8:0]  sh0;
  logic        ovf0;
  logic        ovf1;
  logic        wr_ctl;
  logic        split0;

  assign m0 = timer_mode_t'(timer_mode_r[MODE_MSB:MODE_LSB]);
  assign m1 = timer_mode_t'(timer_mode_r[NIBBLE_ONE+MODE_MSB:
                                         NIBBLE_ONE+MODE_LSB]);
  assign split0 = (m0 == MODE_SPLIT);
  assign tick0 = timer_mode_r[SELECT_BIT] ? fall[PIN_CNT_ZERO]
                                          : half_rate_r;
  assign tick1 = timer_mode_r[NIBBLE_ONE+SELECT_BIT]
               ? fall[PIN_CNT_ONE] : half_rate_r;
  assign en0 = timer_control_r[RUN_ZERO_BIT] &
               (~timer_mode_r[GATE_BIT] |
                sync_r[PIN_EXT_ZERO]);
  assign en1 = timer_control_r[RUN_ONE_BIT] &
               (~timer_mode_r[NIBBLE_ONE+GATE_BIT] |
                sync_r[PIN_EXT_ONE]);
  assign adv0 = en0 & tick0;
  // mode 11 of timer one is a stop
  assign adv1 = en1 & tick1 & (m1 != MODE_SPLIT);
  // split high byte always times and borrows timer one's run bit
  assign adv_h0 = split0 & timer_control_r[RUN_ONE_BIT] &
                  half_rate_r;
  assign st0 = step(m0, timer_zero_low_byte_r,
                    timer_zero_high_byte_r);
  assign st1 = step(m1, timer_one_low_byte_r,
                    timer_one_high_byte_r);
  assign sh0 = {1'b0, timer_zero_high_byte_r} + 9'h001;
  assign ovf0 = adv0 & st0[16];
  // while split, timer one's own overflow cannot reach its flag
  assign ovf1 = (adv1 & st1[16] & ~split0) |
                (adv_h0 & sh0[8]);
  assign wr_ctl = wr_in & hit(addr_in, TIMER_CONTROL_ADDR);

  // a write wins over counting on the same byte
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      timer_zero_low_byte_r <= RESET_BYTE;
    else if (wr_in && hit(addr_in, T0_LOW_ADDR))
      timer_zero_low_byte_r <= wr_data_in;
    else if (adv0)
      timer_zero_low_byte_r <= st0[7:0];
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      timer_zero_high_byte_r <= RESET_BYTE;
    else if (wr_in && hit(addr_in, T0_HIGH_ADDR))
      timer_zero_high_byte_r <= wr_data_in;
    else if (split0) begin
      if (adv_h0)
        timer_zero_high_byte_r <= sh0[7:0];
    end else if (adv0)
      timer_zero_high_byte_r <= st0[15:8];
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      timer_one_low_byte_r <= RESET_BYTE;
    else if (wr_in && hit(addr_in, T1_LOW_ADDR))
      timer_one_low_byte_r <= wr_data_in;
    else if (adv1)
      timer_one_low_byte_r <= st1[7:0];
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      timer_one_high_byte_r <= RESET_BYTE;
    else if (wr_in && hit(addr_in, T1_HIGH_ADDR))
      timer_one_high_byte_r <= wr_data_in;
    else if (adv1)
      timer_one_high_byte_r <= st1[15:8];
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      timer_mode_r <= RESET_BYTE;
    else if (wr_in && hit(addr_in, TIMER_MODE_ADDR))
      timer_mode_r <= wr_data_in;
  end

  // hardware set wins over both the software write and the ack
  logic [7:0] ctl_nxt;
  always_comb begin
    ctl_nxt = wr_ctl ? wr_data_in : timer_control_r;
    if (!wr_ctl) begin
      if (ack_timer_one_in)
        ctl_nxt[OVF_ONE_BIT] = 1'b0;
      if (ack_timer_zero_in)
        ctl_nxt[OVF_ZERO_BIT] = 1'b0;
      if (ack_ext_one_in)
        ctl_nxt[EXT_ONE_FLAG] = 1'b0;
      if (ack_ext_zero_in)
        ctl_nxt[EXT_ZERO_FLAG] = 1'b0;
    end
    if (ovf1)
      ctl_nxt[OVF_ONE_BIT] = 1'b1;
    if (ovf0)
      ctl_nxt[OVF_ZERO_BIT] = 1'b1;
    if (fall[PIN_EXT_ONE])
      ctl_nxt[EXT_ONE_FLAG] = 1'b1;
    if (fall[PIN_EXT_ZERO])
      ctl_nxt[EXT_ZERO_FLAG] = 1'b1;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      timer_control_r <= RESET_BYTE;
    else
      timer_control_r <= ctl_nxt;
  end

  // level mode follows the inverted pin (request while low); edge mode follows the sticky flag
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_zero_req_r <= 1'b0;
      ext_one_req_r  <= 1'b0;
    end else begin
      ext_zero_req_r <= timer_control_r[EXT_ZERO_EDGE]
                      ? timer_control_r[EXT_ZERO_FLAG]
                      : ~sync_r[PIN_EXT_ZERO];
      ext_one_req_r  <= timer_control_r[EXT_ONE_EDGE]
                      ? timer_control_r[EXT_ONE_FLAG]
                      : ~sync_r[PIN_EXT_ONE];
    end
  end

  // unmapped or idle reads return zero
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      rd_data_r <= RESET_BYTE;
    else if (!rd_in)
      rd_data_r <= RESET_BYTE;
    else begin
      case (addr_in)
        TIMER_CONTROL_ADDR: rd_data_r <= timer_control_r;
        TIMER_MODE_ADDR:    rd_data_r <= timer_mode_r;
        T0_LOW_ADDR:        rd_data_r <= timer_zero_low_byte_r;
        T1_LOW_ADDR:        rd_data_r <= timer_one_low_byte_r;
        T0_HIGH_ADDR:       rd_data_r <= timer_zero_high_byte_r;
        T1_HIGH_ADDR:       rd_data_r <= timer_one_high_byte_r;
        default:            rd_data_r <= RESET_BYTE;
      endcase
    end
  end

  assign rd_data_out                  = rd_data_r;
  assign ext_irq_zero_req_out         = ext_zero_req_r;
  assign ext_irq_one_req_out          = ext_one_req_r;
  assign timer_zero_overflow_flag_out = timer_control_r[OVF_ZERO_BIT];
  assign timer_one_overflow_flag_out  = timer_control_r[OVF_ONE_BIT];

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_ovf_one_set: assert property (ovf1 |=>
    timer_one_overflow_flag_out)
    else $error("timer one overflow did not set its flag");
  chk_ovf_zero_set: assert property (ovf0 |=>
    timer_zero_overflow_flag_out)
    else $error("timer zero overflow did not set its flag");
  chk_run_one_hold: assert property (!timer_control_r[RUN_ONE_BIT]
    && !wr_in |=> $stable(timer_one_low_byte_r) &&
    $stable(timer_one_high_byte_r))
    else $error("timer one moved while stopped");
  chk_run_zero_hold: assert property (!en0 && !wr_in
    |=> $stable(timer_zero_low_byte_r))
    else $error("timer zero low byte moved while disabled");
  chk_ext_one_edge: assert property (fall[PIN_EXT_ONE] |=>
    timer_control_r[EXT_ONE_FLAG])
    else $error("ext one falling edge lost");
  chk_ext_zero_edge: assert property (prev_r[PIN_EXT_ZERO] &&
    !sync_r[PIN_EXT_ZERO] |=> timer_control_r[EXT_ZERO_FLAG])
    else $error("ext zero falling edge lost");
  chk_level_zero_req: assert property (!timer_control_r[EXT_ZERO_EDGE]
    && !sync_r[PIN_EXT_ZERO] |=> ext_irq_zero_req_out)
    else $error("level request not raised for low pin");
  chk_gate_zero_block: assert property (timer_mode_r[GATE_BIT] &&
    !sync_r[PIN_EXT_ZERO] && !wr_in |=> $stable(timer_zero_low_byte_r))
    else $error("gated timer zero counted with pin low");
  chk_reload_one: assert property (adv1 && m1 == MODE_RELOAD &&
    st1[16] && !wr_in |=> timer_one_low_byte_r ==
    $past(timer_one_high_byte_r))
    else $error("timer one reload value wrong");
  // two enabled timer-mode cycles must give exactly one step
  chk_timer_tick_rate: assert property ((en0 && !wr_in &&
    m0 == MODE_WIDE && !timer_mode_r[SELECT_BIT])[*2] |=>
    timer_zero_low_byte_r == $past(timer_zero_low_byte_r, 2) + 8'h01)
    else $error("timer zero tick rate wrong");
  chk_level_one_req: assert property (!timer_control_r[EXT_ONE_EDGE]
    && !sync_r[PIN_EXT_ONE] |=> ext_irq_one_req_out)
    else $error("level request not raised for low pin one");
  chk_edge_one_req: assert property (timer_control_r[EXT_ONE_EDGE]
    |=> ext_irq_one_req_out == $past(timer_control_r[EXT_ONE_FLAG]))
    else $error("edge request one does not follow its flag");
  chk_edge_zero_req: assert property (timer_control_r[EXT_ZERO_EDGE]
    |=> ext_irq_zero_req_out == $past(timer_control_r[EXT_ZERO_FLAG]))
    else $error("edge request zero does not follow its flag");
  chk_gate_one_block: assert property (
    timer_mode_r[NIBBLE_ONE+GATE_BIT] && !sync_r[PIN_EXT_ONE] && !wr_in
    |=> $stable(timer_one_low_byte_r))
    else $error("gated timer one counted with pin low");
  chk_count_pin_one: assert property (
    timer_mode_r[NIBBLE_ONE+SELECT_BIT] && !fall[PIN_CNT_ONE] && !wr_in
    |=> $stable(timer_one_low_byte_r))
    else $error("timer one counted without a pin fall");
  chk_stop_one: assert property (m1 == MODE_SPLIT && !wr_in
    |=> $stable(timer_one_low_byte_r) && $stable(timer_one_high_byte_r))
    else $error("timer one moved in its stop mode");
  chk_prescale_top: assert property (m0 == MODE_PRESCALED && !wr_in
    |=> timer_zero_low_byte_r[7:PRESCALE_BITS] ==
    $past(timer_zero_low_byte_r[7:PRESCALE_BITS]))
    else $error("prescaler mode touched the upper low-byte bits");
  chk_reload_zero: assert property (adv0 && m0 == MODE_RELOAD &&
    st0[16] && !wr_in |=> timer_zero_low_byte_r ==
    $past(timer_zero_high_byte_r))
    else $error("timer zero reload value wrong");
  chk_split_high: assert property (split0 &&
    !timer_control_r[RUN_ONE_BIT] && !wr_in
    |=> $stable(timer_zero_high_byte_r))
    else $error("split high byte ran without timer one run bit");
  chk_low_zero_write: assert property (wr_in &&
    addr_in == T0_LOW_ADDR |=> timer_zero_low_byte_r == $past(wr_data_in))
    else $error("timer zero low byte write lost");
  chk_high_one_write: assert property (wr_in &&
    addr_in == T1_HIGH_ADDR |=> timer_one_high_byte_r == $past(wr_data_in))
    else $error("timer one high byte write lost");
  chk_mode_read: assert property (rd_in &&
    addr_in == TIMER_MODE_ADDR |=> rd_data_out == $past(timer_mode_r))
    else $error("mode register read back wrong");
  chk_ack_clears: assert property (ack_timer_zero_in && !wr_ctl &&
    !ovf0 |=> !timer_zero_overflow_flag_out)
    else $error("acknowledge did not clear timer zero flag");

  cov_ovf_zero:  cover property (ovf0);
  cov_split_one: cover property (split0 && adv_h0 && sh0[8]);
  cov_ext_ack:   cover property (fall[PIN_EXT_ONE] && ack_ext_one_in);
  cov_reload:    cover property (adv0 && m0 == MODE_RELOAD && st0[16]);
  cov_count_pin: cover property (adv1 &&
                                 timer_mode_r[NIBBLE_ONE+SELECT_BIT]);
endmodule : dual_timer

// ---- tb_top.sv ----
// self-checking bench for the dual timer block
// assumes the core model answers requests only while enabled
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic       sys_clk_in, sys_rst_in, wr_in, rd_in, ack_en;
  logic [7:0] addr_in, wr_data_in, rd_data_out, v, w, u;
  logic [3:0] pins, req, ack, ack_dly;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cycles = 0;

  dual_timer i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out),
    .ext_irq_zero_pin_in(pins[PIN_EXT_ZERO]),
    .ext_irq_one_pin_in(pins[PIN_EXT_ONE]),
    .count_zero_pin_in(pins[PIN_CNT_ZERO]),
    .count_one_pin_in(pins[PIN_CNT_ONE]),
    .ack_timer_zero_in(ack[0]), .ack_timer_one_in(ack[1]),
    .ack_ext_zero_in(ack[2]), .ack_ext_one_in(ack[3]),
    .ext_irq_zero_req_out(req[2]), .ext_irq_one_req_out(req[3]),
    .timer_zero_overflow_flag_out(req[0]),
    .timer_one_overflow_flag_out(req[1]));

  core_model i_core (.clk_in(sys_clk_in), .rst_in(sys_rst_in),
    .en_in(ack_en), .delay_in(ack_dly), .req_in(req), .ack_out(ack));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // a hang counts as a failure rather than running forever
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    // read data stand only until this edge; sample before it moves
    @(posedge sys_clk_in);
    d = rd_data_out;
  endtask : rd

  task automatic see(input int i, input logic e);
    @(posedge sys_clk_in);
    chk({7'h0, req[i]}, {7'h0, e});
  endtask : see

  task automatic rng(input logic [7:0] x, input logic [7:0] lo, hi);
    chk(8'((x >= lo) && (x <= hi)), 8'h01);
  endtask : rng

  task automatic clr;
    for (int a = 8'h8a; a <= 8'h8d; a++) wr(8'(a), 8'h00);
  endtask : clr

  task automatic t_regs;
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(8'(a), v);
      chk(v, RESET_BYTE);
    end
    wr(TIMER_MODE_ADDR, 8'ha5);
    wr(8'h90, 8'hff);
    rd(TIMER_MODE_ADDR, v);
    chk(v, 8'ha5);
    rd(8'h90, v);
    chk(v, 8'h00);
    wr(T0_LOW_ADDR, 8'h5a);
    rd(T0_LOW_ADDR, v);
    chk(v, 8'h5a);
  endtask : t_regs

  task automatic t_freeze;
    wr(TIMER_MODE_ADDR, 8'h11);
    clr;
    wr(TIMER_CONTROL_ADDR, 8'h50);
    cyc(20);
    wr(TIMER_CONTROL_ADDR, 8'h00);
    rd(T0_LOW_ADDR, v);
    rng(v, 8'h09, 8'h0d);
    rd(T1_LOW_ADDR, w);
    rng(w, 8'h09, 8'h0d);
    cyc(10);
    rd(T0_LOW_ADDR, u);
    chk(u, v);
    rd(T1_LOW_ADDR, u);
    chk(u, w);
  endtask : t_freeze

  task automatic t_ovf;
    wr(TIMER_MODE_ADDR, 8'h01);
    clr;
    wr(T0_LOW_ADDR, 8'hfe);
    wr(T0_HIGH_ADDR, 8'hff);
    wr(TIMER_CONTROL_ADDR, 8'h10);
    cyc(8);
    see(0, 1'b1);
    rd(TIMER_CONTROL_ADDR, v);
    chk(v, 8'h30);
    rd(T0_HIGH_ADDR, v);
    chk(v, 8'h00);
    cyc(20);
    see(0, 1'b1);
    ack_dly <= 4'h3;
    ack_en  <= 1'b1;
    cyc(10);
    see(0, 1'b0);
    ack_en <= 1'b0;
    wr(TIMER_CONTROL_ADDR, 8'h00);
  endtask : t_ovf

  task automatic t_modes;
    wr(TIMER_MODE_ADDR, 8'h00);
    wr(T0_LOW_ADDR, 8'hfe);
    wr(T0_HIGH_ADDR, 8'hff);
    wr(TIMER_CONTROL_ADDR, 8'h10);
    cyc(8);
    see(0, 1'b1);
    wr(TIMER_CONTROL_ADDR, 8'h00);
    rd(T0_LOW_ADDR, v);
    chk(v & 8'he0, 8'he0);
    wr(TIMER_MODE_ADDR, 8'h22);
    wr(T0_HIGH_ADDR, 8'h80);
    wr(T1_HIGH_ADDR, 8'h80);
    wr(T0_LOW_ADDR, 8'hfe);
    wr(T1_LOW_ADDR, 8'hfe);
    wr(TIMER_CONTROL_ADDR, 8'h50);
    cyc(8);
    see(0, 1'b1);
    see(1, 1'b1);
    wr(TIMER_CONTROL_ADDR, 8'h00);
    rd(T0_LOW_ADDR, v);
    rng(v, 8'h80, 8'h88);
    rd(T1_LOW_ADDR, v);
    rng(v, 8'h80, 8'h88);
    rd(T1_HIGH_ADDR, v);
    chk(v, 8'h80);
    wr(TIMER_MODE_ADDR, 8'h03);
    clr;
    wr(T0_HIGH_ADDR, 8'hfe);
    wr(TIMER_CONTROL_ADDR, 8'h40);
    cyc(8);
    see(1, 1'b1);
    see(0, 1'b0);
    rd(T0_LOW_ADDR, v);
    chk(v, 8'h00);
    wr(TIMER_MODE_ADDR, 8'h30);
    clr;
    cyc(10);
    rd(T1_LOW_ADDR, v);
    chk(v, 8'h00);
    wr(TIMER_CONTROL_ADDR, 8'h00);
  endtask : t_modes

  task automatic t_gate;
    wr(TIMER_MODE_ADDR, 8'h09);
    clr;
    pins[PIN_EXT_ZERO] <= 1'b0;
    wr(TIMER_CONTROL_ADDR, 8'h10);
    cyc(20);
    rd(T0_LOW_ADDR, v);
    chk(v, 8'h00);
    pins[PIN_EXT_ZERO] <= 1'b1;
    cyc(20);
    rd(T0_LOW_ADDR, v);
    rng(v, 8'h07, 8'h0d);
    wr(TIMER_CONTROL_ADDR, 8'h00);
  endtask : t_gate

  task automatic t_count;
    for (int i = 0; i < 2; i++) begin
      wr(TIMER_MODE_ADDR, i ? 8'h50 : 8'h05);
      clr;
      wr(TIMER_CONTROL_ADDR, i ? 8'h40 : 8'h10);
      repeat (5) begin
        pins[i ? PIN_CNT_ONE : PIN_CNT_ZERO] <= 1'b0;
        cyc(4);
        pins[i ? PIN_CNT_ONE : PIN_CNT_ZERO] <= 1'b1;
        cyc(4);
      end
      wr(TIMER_CONTROL_ADDR, 8'h00);
      rd(i ? T1_LOW_ADDR : T0_LOW_ADDR, v);
      chk(v, 8'h05);
    end
  endtask : t_count

  // ext pin index equals the request bit offset minus two
  task automatic t_ext;
    for (int i = 0; i < 2; i++) begin
      wr(TIMER_CONTROL_ADDR, i ? 8'h04 : 8'h01);
      pins[i] <= 1'b0;
      cyc(6);
      see(2 + i, 1'b1);
      rd(TIMER_CONTROL_ADDR, v);
      chk(v, i ? 8'h0c : 8'h03);
      pins[i] <= 1'b1;
      cyc(4);
      see(2 + i, 1'b1);
      ack_dly <= 4'h0;
      ack_en  <= 1'b1;
      cyc(6);
      see(2 + i, 1'b0);
      ack_en <= 1'b0;
      wr(TIMER_CONTROL_ADDR, 8'h00);
      pins[i] <= 1'b0;
      cyc(6);
      see(2 + i, 1'b1);
      pins[i] <= 1'b1;
      cyc(6);
      see(2 + i, 1'b0);
      wr(TIMER_CONTROL_ADDR, 8'h00);
    end
  endtask : t_ext

  initial begin
    sys_rst_in = 1'b1;
    addr_in    = 8'h00;
    wr_data_in = 8'h00;
    wr_in      = 1'b0;
    rd_in      = 1'b0;
    pins       = 4'hf;
    ack_en     = 1'b0;
    ack_dly    = 4'h0;
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_regs;
    t_freeze;
    t_ovf;
    t_modes;
    t_gate;
    t_count;
    t_ext;
    stop_test;
  end
endmodule : tb_top

// ---- timer_pkg.sv ----
// constants shared by the dual timer/counter block
// assumes an 8-bit special-function register bus from the core
package timer_pkg;
  // register byte addresses
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
  localparam logic [7:0] TIMER_MODE_ADDR    = 8'h89;
  localparam logic [7:0] T0_LOW_ADDR        = 8'h8a;
  localparam logic [7:0] T1_LOW_ADDR        = 8'h8b;
  localparam logic [7:0] T0_HIGH_ADDR       = 8'h8c;
  localparam logic [7:0] T1_HIGH_ADDR       = 8'h8d;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  // timer_control bit positions
  localparam int OVF_ONE_BIT   = 7;
  localparam int RUN_ONE_BIT   = 6;
  localparam int OVF_ZERO_BIT  = 5;
  localparam int RUN_ZERO_BIT  = 4;
  localparam int EXT_ONE_FLAG  = 3;
  localparam int EXT_ONE_EDGE  = 2;
  localparam int EXT_ZERO_FLAG = 1;
  localparam int EXT_ZERO_EDGE = 0;
  // timer_mode: one nibble per timer, timer one in the upper nibble
  localparam int NIBBLE_ONE    = 4;
  localparam int GATE_BIT      = 3;
  localparam int SELECT_BIT    = 2;
  localparam int MODE_MSB      = 1;
  localparam int MODE_LSB      = 0;
  // synchronised pin vector indices
  localparam int PIN_EXT_ZERO  = 0;
  localparam int PIN_EXT_ONE   = 1;
  localparam int PIN_CNT_ZERO  = 2;
  localparam int PIN_CNT_ONE   = 3;
  localparam int PIN_COUNT     = 4;
  // low-byte prescaler width in the 13-bit mode
  localparam int PRESCALE_BITS = 5;
  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'b00,
    MODE_WIDE      = 2'b01,
    MODE_RELOAD    = 2'b10,
    MODE_SPLIT     = 2'b11
  } timer_mode_t;
endpackage : timer_pkg
